// ---- logic/maint_pkg.sv ----
// constants and types of the maintenance hours counter
// Function
// - wipe level clears done, wipe edge reloads left span
// - full-wipe edge also zeroes run hours
// - monitor high advances run, decrements left
// - done set once left span is zero
// - wipe-only mode: wipes alone drop done
// - wipe-or-idle mode: monitor low drops too
// - run hours count regardless of wipe
// - run hours saturate at upper limit
// - service span in hours and minutes
// - run preset only in configuration mode
// - span change loads left span directly
// - spans and run hours survive power loss
// - external span value taken as hours
// - preset refused while operating
package maint_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SPAN = 8'h04;
  localparam logic [7:0] OFF_PRESET = 8'h08;
  localparam logic [7:0] OFF_RUN = 8'h0c;
  localparam logic [7:0] OFF_LEFT = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;

  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_CFG_BIT = 1;
  localparam int CTRL_EXT_BIT = 2;
  localparam int CTRL_W = 3;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_MON_BIT = 1;

  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_SAT_BIT = 1;
  localparam int IRQ_W = 2;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // time values, span and run counts held in minutes
  // ----------------------------------------------------------------
  localparam int SPAN_W = 20;
  localparam int RUN_W = 23;
  localparam int EXT_W = 14;
  localparam int MIN_PER_H = 60;
  localparam int MAX_MIN = 59;
  localparam int SPAN_MAX_H = 9999;
  localparam int RUN_MAX_H = 99999;
  localparam logic [RUN_W-1:0] RUN_MAX = RUN_W'(RUN_MAX_H * MIN_PER_H);

  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_S = 60;
  localparam int TICK_CYCLES = CLK_HZ * TICK_S;
  localparam int TICK_W = 30;

  // hours and minutes as seen in a register word
  typedef struct packed {
    logic [1:0] pad_hi;
    logic [5:0] mins;
    logic [6:0] pad_lo;
    logic [16:0] hours;
  } hm_t;

  typedef enum logic {
    CLR_WIPE = 1'b0,
    CLR_WIPE_IDLE = 1'b1
  } clr_mode_t;

endpackage // maint_pkg

// ---- logic/maintenance_hours_counter.sv ----
// operating-hours and service-interval counter with axi4-lite registers
module maintenance_hours_counter #(
  parameter int unsigned TICK_CYCLES = maint_pkg::TICK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic keep_on_reset,
  input wire logic monitor_in,
  input wire logic wipe_in,
  input wire logic full_wipe_in,
  input wire logic [maint_pkg::EXT_W-1:0] ext_span_hours,
  input wire logic [maint_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [maint_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic done_out,
  output logic irq
);
  import maint_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [RUN_W-1:0] to_min(input hm_t v, input int maxh);
    logic [RUN_W-1:0] h;
    logic [RUN_W-1:0] m;
    h = (v.hours > 17'(maxh)) ? RUN_W'(maxh) : RUN_W'(v.hours);
    m = (v.mins > 6'(MAX_MIN)) ? RUN_W'(MAX_MIN) : RUN_W'(v.mins);
    return h * RUN_W'(MIN_PER_H) + m;
  endfunction

  function automatic hm_t to_hm(input logic [RUN_W-1:0] v);
    hm_t r;
    r = '0;
    r.hours = 17'(v / RUN_W'(MIN_PER_H));
    r.mins = 6'(v % RUN_W'(MIN_PER_H));
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_have_q, w_have_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [IRQ_W-1:0] irq_stat_q, irq_mask_q;
  logic irq_q, done_q;
  logic [SPAN_W-1:0] span_reg_q, span_prev_q, left_q;
  logic [RUN_W-1:0] run_q;
  logic wiped_q;
  logic wipe_prev_q, full_prev_q;
  logic [TICK_W-1:0] tick_cnt_q;
  logic tick_q;

  // ----------------------------------------------------------------
  // decoding
  // ----------------------------------------------------------------
  wire wr_fire = aw_have_q && w_have_q && !bvalid_q;
  wire wr_ctrl = wr_fire && waddr_q == OFF_CTRL;
  wire wr_span = wr_fire && waddr_q == OFF_SPAN;
  wire wr_preset = wr_fire && waddr_q == OFF_PRESET;
  wire wr_istat = wr_fire && waddr_q == OFF_IRQ_STAT;
  wire wr_imask = wr_fire && waddr_q == OFF_IRQ_MASK;
  wire cfg_mode = ctrl_q[CTRL_CFG_BIT];
  wire preset_ok = wr_preset && cfg_mode;
  wire preset_bad = wr_preset && !cfg_mode;
  wire wr_mapped = wr_ctrl || wr_span || wr_preset || wr_istat || wr_imask
    || (waddr_q == OFF_RUN) || (waddr_q == OFF_LEFT)
    || (waddr_q == OFF_STATUS);
  wire [1:0] wr_resp = (wr_mapped && !preset_bad) ? RESP_OKAY : RESP_SLVERR;

  wire clr_mode_t clr_mode = clr_mode_t'(ctrl_q[CTRL_MODE_BIT]);
  wire [31:0] wmerged_span = merge(32'(to_hm(RUN_W'(span_reg_q))),
    wdata_q, wstrb_q);
  wire [SPAN_W-1:0] span_wr = SPAN_W'(to_min(hm_t'(wmerged_span),
    SPAN_MAX_H));
  wire [31:0] wmerged_pre = merge(32'h0, wdata_q, wstrb_q);
  wire [RUN_W-1:0] preset_val = to_min(hm_t'(wmerged_pre), RUN_MAX_H);

  wire [RUN_W-1:0] ext_min = to_min(hm_t'({15'h0, 3'h0, ext_span_hours}),
    SPAN_MAX_H);
  wire [SPAN_W-1:0] eff_span = ctrl_q[CTRL_EXT_BIT] ? SPAN_W'(ext_min)
    : span_reg_q;
  wire [RUN_W-1:0] preset_rem = (eff_span == '0) ? '0
    : preset_val % RUN_W'(eff_span);
  wire [SPAN_W-1:0] preset_left = eff_span - SPAN_W'(preset_rem);

  wire wipe_edge = wipe_in && !wipe_prev_q;
  wire full_edge = full_wipe_in && !full_prev_q;
  wire run_step = tick_q && monitor_in;
  wire run_adv = run_step && run_q < RUN_MAX;
  wire left_adv = run_step && left_q != '0;
  wire span_chg = eff_span != span_prev_q;
  wire cold = !aresetn && !keep_on_reset;

  wire clr_cond = wipe_in || full_wipe_in
    || (clr_mode == CLR_WIPE_IDLE && !monitor_in);
  wire done_d = !clr_cond && (done_q || left_q == '0);

  wire [IRQ_W-1:0] irq_evt = {run_adv && run_q == RUN_MAX - RUN_W'(1),
    done_d && !done_q};
  wire [IRQ_W-1:0] irq_clr = wr_istat
    ? wdata_q[IRQ_W-1:0] & {IRQ_W{wstrb_q[0]}} : '0;
  // set wins over clear
  wire [IRQ_W-1:0] irq_stat_d = (irq_stat_q & ~irq_clr) | irq_evt;

  wire [31:0] rd_mux =
    (araddr == OFF_CTRL) ? 32'(ctrl_q) :
    (araddr == OFF_SPAN) ? 32'(to_hm(RUN_W'(span_reg_q))) :
    (araddr == OFF_PRESET) ? 32'h0 :
    (araddr == OFF_RUN) ? 32'(to_hm(run_q)) :
    (araddr == OFF_LEFT) ? 32'(to_hm(RUN_W'(left_q))) :
    (araddr == OFF_STATUS) ? 32'({monitor_in, done_q}) :
    (araddr == OFF_IRQ_STAT) ? 32'(irq_stat_q) :
    (araddr == OFF_IRQ_MASK) ? 32'(irq_mask_q) : 32'h0;
  wire rd_mapped = araddr <= OFF_IRQ_MASK && araddr[1:0] == 2'h0;

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      waddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (awvalid && awready_q) begin
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
        waddr_q <= awaddr;
      end
      if (wvalid && wready_q) begin
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_resp;
      end
      if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // control, interrupt and time base
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RESET;
      irq_mask_q <= IRQ_RESET;
      irq_stat_q <= IRQ_RESET;
      irq_q <= 1'b0;
      done_q <= 1'b0;
      wipe_prev_q <= 1'b0;
      full_prev_q <= 1'b0;
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= CTRL_W'(merge(32'(ctrl_q), wdata_q, wstrb_q));
      end
      if (wr_imask) begin
        irq_mask_q <= IRQ_W'(merge(32'(irq_mask_q), wdata_q, wstrb_q));
      end
      irq_stat_q <= irq_stat_d;
      irq_q <= |(irq_stat_q & irq_mask_q);
      done_q <= done_d;
      wipe_prev_q <= wipe_in;
      full_prev_q <= full_wipe_in;
      tick_q <= tick_cnt_q == TICK_W'(TICK_CYCLES - 1);
      tick_cnt_q <= (tick_cnt_q == TICK_W'(TICK_CYCLES - 1)) ? '0
        : tick_cnt_q + TICK_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // retained counters
  // ----------------------------------------------------------------
  // kept over power loss
  always_ff @(posedge aclk) begin
    span_prev_q <= eff_span;
    if (cold) begin
      span_reg_q <= '0;
      left_q <= '0;
      run_q <= '0;
      wiped_q <= 1'b0;
    end else if (aresetn) begin
      if (wr_span) begin
        span_reg_q <= span_wr;
      end
      if (full_edge) begin
        run_q <= '0;
      end else if (preset_ok) begin
        run_q <= preset_val;
      end else if (run_adv) begin
        run_q <= run_q + RUN_W'(1);
      end
      if (full_edge || wipe_edge) begin
        wiped_q <= 1'b1;
      end
      if (full_edge || wipe_edge) begin
        left_q <= eff_span;
      end else if (span_chg) begin
        left_q <= eff_span;
      end else if (preset_ok && !wiped_q) begin
        left_q <= preset_left;
      end else if (left_adv) begin
        left_q <= left_q - SPAN_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign done_out = done_q;
  assign irq = irq_q;

endmodule // maintenance_hours_counter

// ---- test/ctl_model.sv ----
// control-side model driving the monitor and clear inputs
module ctl_model (
  input wire logic aclk,
  output logic monitor_in,
  output logic wipe_in,
  output logic full_wipe_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // level drivers
  // ----------------------------------------------------------------
  initial begin
    monitor_in = 1'h0;
    wipe_in = 1'h0;
    full_wipe_in = 1'h0;
  end

  // monitor high for exactly k sampled edges
  task automatic run(input int k);
    @(posedge aclk);
    monitor_in <= 1'h1;
    repeat (k) @(posedge aclk);
    monitor_in <= 1'h0;
  endtask

  task automatic hold(input logic full, input int k);
    @(posedge aclk);
    if (full) full_wipe_in <= 1'h1;
    else wipe_in <= 1'h1;
    repeat (k) @(posedge aclk);
    wipe_in <= 1'h0;
    full_wipe_in <= 1'h0;
  endtask
endmodule // ctl_model

// ---- test/maint_chk.sv ----
// assertion checker for the maintenance hours counter ports
module maint_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic monitor_in,
  input wire logic wipe_in,
  input wire logic full_wipe_in,
  input wire logic done_out,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------
  // done flag and bus timing
  // ----------------------------------------------------------------
  AST_WIPE_DROP: assert property (wipe_in |=> !done_out)
    else $error("done high after wipe level");
  AST_FULL_DROP: assert property (full_wipe_in |=> !done_out)
    else $error("done high after full wipe level");
  AST_DONE_SET: assert property ($rose(done_out) |->
    !$past(wipe_in) && !$past(full_wipe_in))
    else $error("done rose while a clear input was high");
  AST_DONE_HOLD: assert property (
    done_out && monitor_in && !wipe_in && !full_wipe_in |=> done_out)
    else $error("done dropped without a clear condition");
  AST_B_LAT: assert property (
    awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  AST_R_LAT: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  AST_AW_BLOCK: assert property (awvalid && awready |=> !awready)
    else $error("second write accepted while one is open");
  AST_B_DONE: assert property (bvalid && bready |=> !bvalid ##0 awready)
    else $error("write channel not freed after response");
endmodule // maint_chk

bind maintenance_hours_counter maint_chk u_chk (.*);

// ---- test/tb.sv ----
// self-checking bench for the maintenance hours counter
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import maint_pkg::*;
  localparam int TK = 20;
  logic aclk = 1'h0, aresetn = 1'h0, keep_on_reset = 1'h0;
  logic [EXT_W-1:0] ext_span_hours = 14'h0002;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, done_out, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  wire logic monitor_in, wipe_in, full_wipe_in;
  int error_cnt = 0, num_checks = 0;

  maintenance_hours_counter #(.TICK_CYCLES(TK)) dut (.aclk, .aresetn,
    .keep_on_reset, .monitor_in, .wipe_in, .full_wipe_in, .ext_span_hours,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .done_out, .irq);
  ctl_model u_ctl (.aclk, .monitor_in, .wipe_in, .full_wipe_in);

  always #50 aclk = ~aclk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] hm(input int h, input int m);
    hm_t v;
    v = '0;
    v.hours = h[16:0];
    v.mins = m[5:0];
    return v;
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    logic aw_ok = 1'h0;
    logic w_ok = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    // each channel is released at the edge that takes it
    do begin
      @(posedge aclk);
      if (awready) aw_ok = 1'h1;
      if (wready) w_ok = 1'h1;
      if (aw_ok) awvalid <= 1'h0;
      if (w_ok) wvalid <= 1'h0;
    end while (!(aw_ok && w_ok));
    while (!bvalid) @(posedge aclk);
    cmp(bresp, er);
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    while (!rvalid) @(posedge aclk);
    cmp(rdata, ed);
    cmp(rresp, er);
    rready <= 1'h0;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd(OFF_CTRL, 32'h0);
    rd(OFF_IRQ_MASK, 32'h0);
    rd(OFF_RUN, 32'h0);
    rd(8'h20, 32'h0, RESP_SLVERR);
    wr(8'h24, 32'h1, RESP_SLVERR);
    $display("test regs finished");
  endtask

  task automatic t_preset();
    wr(OFF_SPAN, hm(0, 30));
    wr(OFF_CTRL, 32'h2);
    wr(OFF_PRESET, hm(1, 40));
    rd(OFF_RUN, hm(1, 40));
    rd(OFF_LEFT, hm(0, 20));
    wr(OFF_CTRL, 32'h0);
    wr(OFF_PRESET, hm(0, 5), RESP_SLVERR);
    rd(OFF_RUN, hm(1, 40));
    wr(OFF_CTRL, 32'h2);
    wr(OFF_PRESET, hm(99998, 59));
    wr(OFF_CTRL, 32'h0);
    wr(OFF_IRQ_MASK, 32'h2);
    u_ctl.run(3 * TK);
    rd(OFF_RUN, hm(99999, 0));
    cmp(irq, 1'h1);
    wr(OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge aclk);
    cmp(irq, 1'h0);
    $display("test preset finished");
  endtask

  task automatic t_count();
    wr(OFF_SPAN, hm(0, 3));
    rd(OFF_LEFT, hm(0, 3));
    u_ctl.hold(1'h1, 1);
    repeat (2) @(posedge aclk);
    cmp(done_out, 1'h0);
    rd(OFF_RUN, 32'h0);
    rd(OFF_LEFT, hm(0, 3));
    wr(OFF_IRQ_STAT, 32'h3);
    wr(OFF_IRQ_MASK, 32'h1);
    u_ctl.run(2 * TK);
    rd(OFF_RUN, hm(0, 2));
    rd(OFF_LEFT, hm(0, 1));
    cmp(done_out, 1'h0);
    u_ctl.run(TK);
    repeat (2 * TK) @(posedge aclk);
    cmp(done_out, 1'h1);
    cmp(irq, 1'h1);
    rd(OFF_STATUS, 32'h1);
    rd(OFF_RUN, hm(0, 3));
    wr(OFF_IRQ_STAT, 32'h1);
    repeat (2) @(posedge aclk);
    cmp(irq, 1'h0);
    $display("test count finished");
  endtask

  task automatic t_wipe();
    fork
      u_ctl.run(TK);
      u_ctl.hold(1'h0, TK + 2);
    join
    cmp(done_out, 1'h0);
    rd(OFF_RUN, hm(0, 4));
    u_ctl.hold(1'h0, 1);
    rd(OFF_LEFT, hm(0, 3));
    rd(OFF_RUN, hm(0, 4));
    $display("test wipe finished");
  endtask

  task automatic t_mode();
    wr(OFF_CTRL, 32'h1);
    fork
      u_ctl.run(4 * TK);
      begin
        repeat (3 * TK + 5) @(posedge aclk);
        cmp(done_out, 1'h1);
      end
    join
    repeat (3) @(posedge aclk);
    cmp(done_out, 1'h0);
    wr(OFF_CTRL, 32'h4);
    rd(OFF_LEFT, hm(2, 0));
    $display("test mode finished");
  endtask

  task automatic t_retain();
    wr(OFF_CTRL, 32'h0);
    // only the low hours byte is written, minutes are kept
    wstrb <= 4'h1;
    wr(OFF_SPAN, hm(5, 0));
    wstrb <= 4'hf;
    rd(OFF_SPAN, hm(5, 3));
    rd(OFF_LEFT, hm(5, 3));
    // warm reset: counters must survive it
    keep_on_reset <= 1'h1;
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    cmp(done_out, 1'h0);
    rd(OFF_RUN, hm(0, 8));
    rd(OFF_SPAN, hm(5, 3));
    rd(OFF_LEFT, hm(5, 3));
    rd(OFF_CTRL, 32'h0);
    rd(OFF_STATUS, 32'h0);
    $display("test retain finished");
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_preset();
    t_count();
    t_wipe();
    t_mode();
    t_retain();
    conclude();
  end

  initial begin
    #1000000;
    error_cnt++;
    conclude();
  end
endmodule // tb
